// >>> pkg/nibble_cpu_core_datapath_regs.vh
`ifndef NIBBLE_CPU_CORE_DATAPATH_REGS_VH
`define NIBBLE_CPU_CORE_DATAPATH_REGS_VH
// Operation
// - pc is 12 bits: page bit on top, 11-bit ripple counter below
// - unconditional jump loads the page bit, reaching above 2K
// - pc spans only 4K words; wider stores need outside banking
// - binary add/sub with and without carry, register, memory, immediate forms
// - decimal adjust after addition and after subtraction
// - and, or, xor in accumulator, memory and immediate-to-memory forms
// - branch on accumulator bit set, zero, nonzero, carry set or clear
// - carry captures carry or borrow of every add and subtract; decimal adjust after subtraction keeps it
// - call and interrupt push carry; return-from-interrupt restores it
// - return-with-constant pops address but leaves carry alone
// - 4-bit accumulator takes results and moves data to memory
// - table jump target is pc[11:8], table branch reg, accumulator
// - return-with-constant loads word bits 7..4 to table reg, 3..0 to acc
// - indirect pointer is 10 bits: 3-bit high, 3-bit middle, 4-bit low
// - pseudo index access reaches data memory at pointer bits 9..0
// - stack holds eight 13-bit entries, carry in msb, pc below
// - stack is last-in first-out; returns pop the newest entry
// - ninth push drops the oldest entry from the bottom
// - one instruction takes four clock periods
// - vectors 000..004: reset, external, timer, base timer, port

// instruction timing
`define CYCLE_PHASES 4
// stack
`define STK_DEPTH 8
// entry points
`define VEC_RESET 12'h000
`define VEC_EXT 12'h001
`define VEC_TIMER 12'h002
`define VEC_BASE_TIMER 12'h003
`define VEC_PORT 12'h004
// internal locations within the direct address space
`define ADDR_TABLE_BRANCH 7'h0e
`define ADDR_PSEUDO_INDEX 7'h0f
`define ADDR_PTR_LOW 7'h10
`define ADDR_PTR_MID 7'h11
`define ADDR_PTR_HIGH 7'h12
// instruction classes, bits 14..12 with bit 15 low
`define CLS_ALU 3'h0
`define CLS_BRANCH 3'h1
`define CLS_JUMP 3'h2
`define CLS_CALL 3'h3
`define CLS_TJUMP 3'h4
`define CLS_RETW 3'h5
`define CLS_RETI 3'h6
`define CLS_MISC 3'h7
// alu functions, func bits 3..1; func bit 0 selects memory destination
`define FN_ADD 3'h0
`define FN_ADC 3'h1
`define FN_SUB 3'h2
`define FN_SBC 3'h3
`define FN_AND 3'h4
`define FN_OR 3'h5
`define FN_EOR 3'h6
`define FN_MOVE 3'h7
// misc operations
`define MS_SHR 4'h1
`define MS_DAA 4'h2
`define MS_DAS 4'h3
// branch conditions 0..3 test accumulator bit n
`define BR_ZERO 3'h4
`define BR_NZERO 3'h5
`define BR_CARRY 3'h6
`define BR_NCARRY 3'h7
// decimal adjust constants
`define BCD_MAX 4'h9
`define BCD_ADD_FIX 4'h6
`define BCD_SUB_FIX 4'ha
// reset values
`define RST_ACC 4'h0
`define RST_CARRY 1'b0
`define RST_TBR 4'h0
`define RST_PTR_LOW 4'h0
`define RST_PTR_HI 3'h0
`endif

// >>> logic/nibble_cpu_core_datapath.v
`timescale 1ns/1ps
`include "nibble_cpu_core_datapath_regs.vh"
module nibble_cpu_core_datapath #(
    parameter STACK_DEPTH = `STK_DEPTH
)
(
    // clock, reset, enable
    input wire clk,
    input wire rst,
    input wire ce,
    // program rom
    output reg [11:0] romAddr_r,
    input wire [15:0] romData,
    // data ram
    output reg [9:0] ramAddr_r,
    output reg [3:0] ramWrData_r,
    output reg ramWe_r,
    input wire [3:0] ramRdData,
    // interrupt requests, bit 0 highest priority
    input wire [3:0] intReq,
    output reg [3:0] intAck_r,
    // core state
    output reg [3:0] accumulator_nibble_r,
    output reg carry_flag_r,
    output reg instrDone_r
);

localparam PH_FETCH = 4'b0001;
localparam PH_DECODE = 4'b0010;
localparam PH_READ = 4'b0100;
localparam PH_EXEC = 4'b1000;

function [4:0] addc;
    input [3:0] a;
    input [3:0] b;
    input ci;
    begin
        addc = {1'b0, a} + {1'b0, b} + {4'h0, ci};
    end
endfunction

reg [3:0] phase_r;
reg [15:0] ir_r;
reg [3:0] opnd_r;
reg page_bit_r;
reg [10:0] pcLow_r;
reg [3:0] table_branch_reg_r;
reg [3:0] pointer_low_part_r;
reg [2:0] pointer_middle_part_r;
reg [2:0] pointer_high_part_r;
reg inService_r;
reg [12:0] stack_r [0:STACK_DEPTH-1];
integer i;

wire immForm = ir_r[15];
wire [2:0] cls = ir_r[14:12];
wire [3:0] func = immForm ? ir_r[14:11] : ir_r[11:8];
wire [3:0] imm = ir_r[10:7];
wire [6:0] dirAddr = ir_r[6:0];
wire isAlu = immForm || (cls == `CLS_ALU);
wire [11:0] pcCur = {page_bit_r, pcLow_r};
wire [9:0] pointerAddr = {pointer_high_part_r, pointer_middle_part_r,
    pointer_low_part_r};
wire [12:0] stackTop = stack_r[0];
// ripple counter only: the page bit never changes by counting
wire [11:0] pcInc = {page_bit_r, pcLow_r + 11'h001};
wire [3:0] aOp = immForm ? opnd_r : accumulator_nibble_r;
wire [3:0] bOp = immForm ? imm : opnd_r;

reg [4:0] sum;
reg [3:0] res;
reg [3:0] accNxt;
reg cyNxt;
reg memWr;
reg [11:0] pcNxt;
reg doPush;
reg doPop;
reg takeBranch;
reg [3:0] irqSel;
reg [11:0] irqVec;

always @*
begin
    sum = 5'h00;
    res = bOp;
    accNxt = accumulator_nibble_r;
    cyNxt = carry_flag_r;
    memWr = 1'b0;
    pcNxt = pcInc;
    doPush = 1'b0;
    doPop = 1'b0;
    takeBranch = 1'b0;
    if (isAlu)
    begin
        case (func[3:1])
        `FN_ADD:
        begin
            sum = addc(aOp, bOp, 1'b0);
            res = sum[3:0];
            cyNxt = sum[4];
        end
        `FN_ADC:
        begin
            sum = addc(aOp, bOp, carry_flag_r);
            res = sum[3:0];
            cyNxt = sum[4];
        end
        `FN_SUB:
        begin
            // carry flag set means a borrow occurred
            sum = addc(aOp, ~bOp, 1'b1);
            res = sum[3:0];
            cyNxt = ~sum[4];
        end
        `FN_SBC:
        begin
            sum = addc(aOp, ~bOp, ~carry_flag_r);
            res = sum[3:0];
            cyNxt = ~sum[4];
        end
        `FN_AND:
            res = aOp & bOp;
        `FN_OR:
            res = aOp | bOp;
        `FN_EOR:
            res = aOp ^ bOp;
        default:
            // store form writes the accumulator out, others move operand
            res = (func[0] && !immForm) ? accumulator_nibble_r : bOp;
        endcase
        if (func[0])
            memWr = 1'b1;
        else
            accNxt = res;
    end
    else
    begin
        case (cls)
        `CLS_BRANCH:
        begin
            if (!ir_r[10])
                takeBranch = accumulator_nibble_r[ir_r[9:8]];
            else if (ir_r[10:8] == `BR_ZERO)
                takeBranch = (accumulator_nibble_r == 4'h0);
            else if (ir_r[10:8] == `BR_NZERO)
                takeBranch = (accumulator_nibble_r != 4'h0);
            else if (ir_r[10:8] == `BR_CARRY)
                takeBranch = carry_flag_r;
            else
                takeBranch = !carry_flag_r;
            if (takeBranch)
                pcNxt = {pcCur[11:8], ir_r[7:0]};
        end
        `CLS_JUMP:
            pcNxt = ir_r[11:0];
        `CLS_CALL:
        begin
            doPush = 1'b1;
            pcNxt = ir_r[11:0];
        end
        `CLS_TJUMP:
            pcNxt = {pcCur[11:8], table_branch_reg_r, accumulator_nibble_r};
        `CLS_RETW:
        begin
            doPop = 1'b1;
            pcNxt = stackTop[11:0];
            accNxt = ir_r[3:0];
        end
        `CLS_RETI:
        begin
            doPop = 1'b1;
            pcNxt = stackTop[11:0];
            cyNxt = stackTop[12];
        end
        default:
        begin
            if (ir_r[11:8] == `MS_SHR)
                accNxt = {1'b0, accumulator_nibble_r[3:1]};
            else if (ir_r[11:8] == `MS_DAA)
            begin
                if (accumulator_nibble_r > `BCD_MAX || carry_flag_r)
                begin
                    sum = addc(accumulator_nibble_r, `BCD_ADD_FIX, 1'b0);
                    accNxt = sum[3:0];
                    cyNxt = 1'b1;
                end
            end
            else if (ir_r[11:8] == `MS_DAS)
            begin
                if (accumulator_nibble_r > `BCD_MAX || carry_flag_r)
                begin
                    sum = addc(accumulator_nibble_r, `BCD_SUB_FIX, 1'b0);
                    accNxt = sum[3:0];
                end
            end
        end
        endcase
    end
end

// fixed priority; only taken when the instruction itself leaves the stack alone
always @*
begin
    irqSel = 4'h0;
    irqVec = `VEC_RESET;
    if (intReq[0])
    begin
        irqSel = 4'h1;
        irqVec = `VEC_EXT;
    end
    else if (intReq[1])
    begin
        irqSel = 4'h2;
        irqVec = `VEC_TIMER;
    end
    else if (intReq[2])
    begin
        irqSel = 4'h4;
        irqVec = `VEC_BASE_TIMER;
    end
    else if (intReq[3])
    begin
        irqSel = 4'h8;
        irqVec = `VEC_PORT;
    end
end

wire irqTake = (irqSel != 4'h0) && !inService_r && !doPush && !doPop;
wire stackPush = doPush || irqTake;
// a call returns past itself; an interrupt resumes at the next pc
wire [12:0] pushData = {cyNxt, doPush ? pcInc : pcNxt};
wire [11:0] pcFinal = irqTake ? irqVec : pcNxt;

always @(posedge clk)
begin
    if (rst)
    begin
        phase_r <= PH_FETCH;
        ir_r <= 16'h0000;
        opnd_r <= 4'h0;
        page_bit_r <= 1'b0;
        pcLow_r <= 11'h000;
        romAddr_r <= `VEC_RESET;
        ramAddr_r <= 10'h000;
        ramWrData_r <= 4'h0;
        ramWe_r <= 1'b0;
        intAck_r <= 4'h0;
        instrDone_r <= 1'b0;
        accumulator_nibble_r <= `RST_ACC;
        carry_flag_r <= `RST_CARRY;
        table_branch_reg_r <= `RST_TBR;
        pointer_low_part_r <= `RST_PTR_LOW;
        pointer_middle_part_r <= `RST_PTR_HI;
        pointer_high_part_r <= `RST_PTR_HI;
        inService_r <= 1'b0;
        for (i = 0; i < STACK_DEPTH; i = i + 1)
            stack_r[i] <= 13'h0000;
    end
    else if (ce)
    begin
        ramWe_r <= 1'b0;
        intAck_r <= 4'h0;
        instrDone_r <= 1'b0;
        case (phase_r)
        PH_FETCH:
        begin
            ir_r <= romData;
            phase_r <= PH_DECODE;
        end
        PH_DECODE:
        begin
            if (dirAddr == `ADDR_PSEUDO_INDEX)
                ramAddr_r <= pointerAddr;
            else
                ramAddr_r <= {3'h0, dirAddr};
            phase_r <= PH_READ;
        end
        PH_READ:
        begin
            // pointer parts and table reg live here, not in ram
            if (dirAddr == `ADDR_TABLE_BRANCH)
                opnd_r <= table_branch_reg_r;
            else if (dirAddr == `ADDR_PTR_LOW)
                opnd_r <= pointer_low_part_r;
            else if (dirAddr == `ADDR_PTR_MID)
                opnd_r <= {1'b0, pointer_middle_part_r};
            else if (dirAddr == `ADDR_PTR_HIGH)
                opnd_r <= {1'b0, pointer_high_part_r};
            else
                opnd_r <= ramRdData;
            phase_r <= PH_EXEC;
        end
        default:
        begin
            accumulator_nibble_r <= accNxt;
            carry_flag_r <= cyNxt;
            if (cls == `CLS_RETW && !immForm)
                table_branch_reg_r <= ir_r[7:4];
            if (memWr)
            begin
                if (dirAddr == `ADDR_TABLE_BRANCH)
                    table_branch_reg_r <= res;
                else if (dirAddr == `ADDR_PTR_LOW)
                    pointer_low_part_r <= res;
                else if (dirAddr == `ADDR_PTR_MID)
                    pointer_middle_part_r <= res[2:0];
                else if (dirAddr == `ADDR_PTR_HIGH)
                    pointer_high_part_r <= res[2:0];
                else
                begin
                    ramWrData_r <= res;
                    ramWe_r <= 1'b1;
                end
            end
            if (stackPush)
            begin
                // no overflow stop: the oldest entry falls off the bottom
                for (i = STACK_DEPTH - 1; i > 0; i = i - 1)
                    stack_r[i] <= stack_r[i-1];
                stack_r[0] <= pushData;
            end
            else if (doPop)
            begin
                for (i = 0; i < STACK_DEPTH - 1; i = i + 1)
                    stack_r[i] <= stack_r[i+1];
                stack_r[STACK_DEPTH-1] <= 13'h0000;
            end
            if (irqTake)
            begin
                inService_r <= 1'b1;
                intAck_r <= irqSel;
            end
            else if (cls == `CLS_RETI && !immForm)
                inService_r <= 1'b0;
            page_bit_r <= pcFinal[11];
            pcLow_r <= pcFinal[10:0];
            romAddr_r <= pcFinal;
            instrDone_r <= 1'b1;
            phase_r <= PH_FETCH;
        end
        endcase
    end
end

endmodule

// >>> test/nibble_cpu_core_datapath_props.sv
`timescale 1ns/1ps
module nibble_cpu_core_datapath_props #(
    parameter STACK_DEPTH = 8
)
(
    // clock, reset and enable
    input wire clk,
    input wire rst,
    input wire ce,
    // core outputs and requests
    input wire [11:0] romAddr_r,
    input wire [9:0] ramAddr_r,
    input wire ramWe_r,
    input wire [3:0] intReq,
    input wire [3:0] intAck_r,
    input wire [3:0] accumulator_nibble_r,
    input wire carry_flag_r,
    input wire instrDone_r
);
    default clocking dc @(posedge clk);
    endclocking
    // a frozen core holds its pulses, so spacing checks pause with it
    default disable iff (rst || !ce);
    done_gap_a: assert property (instrDone_r |=> !instrDone_r [*3] ##1 instrDone_r)
        else $error("done spacing wrong");
    pc_hold_a: assert property (instrDone_r |=> $stable(romAddr_r) [*3])
        else $error("pc moved mid instruction");
    pc_commit_a: assert property (!$stable(romAddr_r) |-> instrDone_r)
        else $error("pc changed off commit");
    state_commit_a: assert property (!$stable({accumulator_nibble_r, carry_flag_r})
        |-> instrDone_r) else $error("acc or carry changed off commit");
    reset_val_a: assert property ($fell(rst) |-> romAddr_r == 12'h000 && !carry_flag_r
        && accumulator_nibble_r == 4'h0) else $error("bad state after reset");
    we_commit_a: assert property (ramWe_r |-> instrDone_r && $stable(ramAddr_r))
        else $error("write strobe off commit");
    we_pulse_a: assert property (ramWe_r |=> !ramWe_r [*3])
        else $error("write strobe too long");
    ack_vector_a: assert property (intAck_r != 4'h0 |-> romAddr_r ==
        (intAck_r[0] ? 12'h001 : intAck_r[1] ? 12'h002 : intAck_r[2] ? 12'h003 : 12'h004))
        else $error("bad vector");
    ack_prio_a: assert property (intAck_r != 4'h0 |-> instrDone_r &&
        intAck_r == ($past(intReq) & -$past(intReq))) else $error("bad acknowledge");
    cover property (intAck_r[3]);
    cover property (ramWe_r);
    cover property (instrDone_r ##4 instrDone_r);
endmodule

// >>> test/prog_data_mem.sv
`timescale 1ns/1ps
module prog_data_mem
(
    // program side
    input wire clk,
    input wire [11:0] romAddr,
    output wire [15:0] romData,
    // data side
    input wire [9:0] ramAddr,
    input wire [3:0] ramWrData,
    input wire ramWe,
    output wire [3:0] ramRdData
);
    reg [15:0] rom [0:4095];
    reg [3:0] ram [0:1023];
    // unwritten words read as unknown, so stale data cannot pass
    assign romData = rom[romAddr];
    assign ramRdData = ram[ramAddr];
    always @(posedge clk)
    begin
        if (ramWe)
            ram[ramAddr] <= ramWrData;
    end
endmodule

// >>> test/nibble_cpu_core_datapath_tb_top.sv
`timescale 1ns/1ps
module nibble_cpu_core_datapath_tb_top;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg ce = 1'b1;
    reg [3:0] intReq = 4'h0;
    wire [11:0] romAddr;
    wire [15:0] romData;
    wire [9:0] ramAddr;
    wire [3:0] wrData, rdData, ack, acc;
    wire we, carry, done;
    integer seed = 61;
    integer error_cnt = 0;
    integer samples_checked = 0;
    integer i, k;
    reg [3:0] f, a, b, l, v;
    reg [1:0] d;
    reg [4:0] e;
    reg c;
    reg [11:0] p;
    reg [11:0] q [0:8];

    always #25 clk = ~clk;

    nibble_cpu_core_datapath #(.STACK_DEPTH(8)) dut (
        .clk(clk), .rst(rst), .ce(ce), .romAddr_r(romAddr), .romData(romData),
        .ramAddr_r(ramAddr), .ramWrData_r(wrData), .ramWe_r(we), .ramRdData(rdData),
        .intReq(intReq), .intAck_r(ack), .accumulator_nibble_r(acc),
        .carry_flag_r(carry), .instrDone_r(done));
    prog_data_mem mem (
        .clk(clk), .romAddr(romAddr), .romData(romData), .ramAddr(ramAddr),
        .ramWrData(wrData), .ramWe(we), .ramRdData(rdData));

    function [15:0] imm(input [3:0] fn, input [3:0] x, input [6:0] ad);
        imm = {1'b1, fn, x, ad};
    endfunction
    function [15:0] op(input [2:0] cl, input [11:0] x);
        op = {1'b0, cl, x};
    endfunction
    // page bit never takes the counter's carry
    function [11:0] nx(input [11:0] pc);
        nx = {pc[11], pc[10:0] + 11'h001};
    endfunction
    function [4:0] alu(input [3:0] fn, input [4:0] x, input [4:0] y, input ci);
        case (fn)
            0: alu = x + y;
            1: alu = x + y + ci;
            2: alu = x - y;
            3: alu = x - y - ci;
            4: alu = {ci, x[3:0] & y[3:0]};
            5: alu = {ci, x[3:0] | y[3:0]};
            6: alu = {ci, x[3:0] ^ y[3:0]};
            7: alu = {ci, x[4:1]};
            8: alu = (x > 9 || ci) ? {1'b1, x[3:0] + 4'h6} : {ci, x[3:0]};
            default: alu = (x > 9 || ci) ? {ci, x[3:0] + 4'ha} : {ci, x[3:0]};
        endcase
    endfunction
    function tk(input [2:0] cd, input [3:0] x, input cy);
        case (cd)
            4: tk = x == 4'h0;
            5: tk = x != 4'h0;
            6: tk = cy;
            7: tk = !cy;
            default: tk = x[cd[1:0]];
        endcase
    endfunction

    task conclude;
    begin
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    end
    endtask
    task chk(input [47:0] nm, input [11:0] exp, input [11:0] got);
    begin
        samples_checked = samples_checked + 1;
        if (got !== exp)
        begin
            error_cnt = error_cnt + 1;
            $display("Error %0s expected %h seen %h", nm, exp, got);
        end
    end
    endtask
    // one instruction placed at the current pc, then wait for its commit
    task run(input [15:0] ins);
    begin
        mem.rom[romAddr] = ins;
        k = 0;
        @(posedge clk);
        #1;
        while (done !== 1'b1 && k < 20)
        begin
            @(posedge clk);
            #1;
            k = k + 1;
        end
        if (k == 20)
        begin
            chk("hang", 0, 1);
            conclude;
        end
    end
    endtask
    // carry from 15 + cv, then acc loaded by move
    task setst(input [3:0] av, input cv);
    begin
        run(imm(4'hf, 4'hf, 7'h21));
        run(imm(4'h0, {3'h0, cv}, 7'h21));
        run(imm(4'he, av, 7'h21));
    end
    endtask
    task doReset;
    begin
        rst = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        rst = 1'b0;
        chk("pc", 12'h000, romAddr);
        chk("acc", 4'h0, acc);
        chk("carry", 1'b0, carry);
        $display("test reset finished");
    end
    endtask

    initial
    begin
        for (i = 0; i < 4096; i = i + 1)
            mem.rom[i] = 16'h7000;
        doReset;
        for (i = 0; i < 60; i = i + 1)
        begin
            f = $unsigned($random(seed)) % 10;
            {a, b, c, d} = $random(seed);
            if (i < 4)
                {f, a} = {4'h8 + i[0], 4'h9 + i[1]};
            run(imm(4'hf, d[1] ? a : b, 7'h20));
            setst(a, c);
            if (f > 6)
                run(op(3'h7, {f - 4'h6, 8'h00}));
            else if (d[1])
                run(imm({f[2:0], d[0]}, b, 7'h20));
            else
                run(op(3'h0, {f[2:0], d[0], 1'b0, 7'h20}));
            e = alu(f, a, b, c);
            if (d[0] && f < 7)
            begin
                chk("we", 1, we);
                chk("wdata", e[3:0], wrData);
                chk("acc", a, acc);
            end
            else
                chk("acc", e[3:0], acc);
            chk("carry", e[4], carry);
        end
        $display("test alu finished");
        for (i = 0; i < 32; i = i + 1)
        begin
            a = i[4] ? 4'h0 : $random(seed);
            c = $random(seed);
            setst(a, c);
            p = romAddr;
            run(op(3'h1, {1'b0, i[2:0], 8'h5a}));
            chk("pc", tk(i[2:0], a, c) ? {p[11:8], 8'h5a} : nx(p), romAddr);
        end
        for (i = 0; i < 3; i = i + 1)
        begin
            p = i == 0 ? 12'h9f0 : i == 1 ? 12'h7ff : 12'hfff;
            run(op(3'h2, p));
            chk("pc", p, romAddr);
            run(16'h7000);
            chk("pc", nx(p), romAddr);
        end
        $display("test branch finished");
        for (i = 0; i < 9; i = i + 1)
        begin
            setst(4'h0, i[0]);
            q[i] = nx(romAddr);
            run(op(3'h3, 12'h200 + i * 16));
            chk("pc", 12'h200 + i * 16, romAddr);
        end
        // ninth call has pushed the first entry out
        for (i = 8; i > 0; i = i - 1)
        begin
            setst(4'h0, !i[0]);
            run(op(i > 4 ? 3'h6 : 3'h5, {4'h0, 8'hc0 + i[7:0]}));
            chk("pc", q[i], romAddr);
            chk("carry", i > 4 ? i[0] : !i[0], carry);
            if (i < 5)
            begin
                chk("acc", i[3:0], acc);
                run(op(3'h4, 12'h000));
                chk("pc", {q[i][11:8], 4'hc, i[3:0]}, romAddr);
            end
        end
        $display("test stack finished");
        for (i = 0; i < 4; i = i + 1)
        begin
            setst(4'h0, i[0]);
            p = romAddr;
            intReq = (4'h1 << i) | ($random(seed) & ~((4'h2 << i) - 1));
            run(16'h7000);
            chk("ack", 4'h1 << i, ack);
            chk("pc", i + 1, romAddr);
            intReq = 4'h0;
            setst(4'h0, !i[0]);
            run(op(3'h6, 12'h000));
            chk("pc", nx(p), romAddr);
            chk("carry", i[0], carry);
        end
        $display("test interrupt finished");
        for (i = 0; i < 4; i = i + 1)
        begin
            {a, b, l, v} = $random(seed);
            if (i == 0)
                {a, b, l} = 12'hfff;
            run(imm(4'hf, a, 7'h12));
            run(imm(4'hf, b, 7'h11));
            run(imm(4'hf, l, 7'h10));
            chk("we", 0, we);
            run(imm(4'hf, v, 7'h0f));
            chk("addr", {a[2:0], b[2:0], l}, ramAddr);
            chk("wdata", v, wrData);
            run(op(3'h0, {4'he, 1'b0, 7'h0f}));
            chk("acc", v, acc);
        end
        $display("test pointer finished");
        run(imm(4'hf, 4'h5, 7'h22));
        p = romAddr;
        ce = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk("we", 1, we);
        chk("pc", p, romAddr);
        ce = 1'b1;
        run(op(3'h0, {4'he, 1'b0, 7'h22}));
        chk("acc", 4'h5, acc);
        chk("pc", nx(p), romAddr);
        $display("test enable finished");
        doReset;
        conclude;
    end
endmodule

bind nibble_cpu_core_datapath nibble_cpu_core_datapath_props #(.STACK_DEPTH(STACK_DEPTH)) props (
    .clk(clk), .rst(rst), .ce(ce), .romAddr_r(romAddr_r), .ramAddr_r(ramAddr_r),
    .ramWe_r(ramWe_r),
    .intReq(intReq), .intAck_r(intAck_r), .accumulator_nibble_r(accumulator_nibble_r),
    .carry_flag_r(carry_flag_r), .instrDone_r(instrDone_r));
